// [core/remote_rx_map.svh]
// constants for the remote control pulse receiver
`ifndef REMOTE_RX_MAP_SVH
`define REMOTE_RX_MAP_SVH
`define RX_BUF_BITS 72
`define RX_IDX_W 7
`define RX_CNT_W 8
`define RX_THR_W 7
`define RX_NC_W 4
`define RX_FIFO_DEPTH 32
`define RX_FIFO_W 3
`define RX_CNT_SAT 8'hff
`define RX_CLK_HZ 20000000
`define RX_SAMPLE_HZ 32768
`endif

// [core/remote_rx_pkg.sv]
// types for the remote control pulse receiver
package remote_rx_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DATA = 3'b100
    } rx_state_t;
    typedef enum logic [1:0] {
        PAT_SHORT = 2'h1,
        PAT_MID = 2'h2,
        PAT_LONG = 2'h3
    } pattern_t;
endpackage : remote_rx_pkg

// [core/rx_fifo.sv]
// parameterised fifo with a registered output stage
`timescale 1ns/1ps
module rx_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic wr;
    logic ld;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign wr = in_valid && in_ready;
    // refill the output stage as soon as it is empty or being drained
    assign ld = (cnt_q != '0) && (!out_valid || out_ready);

    always_ff @(posedge clock) begin
        if (clk_en && wr) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (ld) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(ld);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (clk_en) begin
            if (ld) begin
                out_valid <= 1'b1;
                out_data <= mem[rp_q];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : rx_fifo

// [core/remote_rx.sv]
// remote control pulse-width receiver: leader, bit decode and completion
// Summary of operation
// [RL1] low beyond limit after data fall flagged
// [RL2] excess low ends reception, raises interrupt
// [RL3] excess low sets low overflow flag
// [RL4] enabled receiver waits for leader first
// [RL5] software leaves config alone while receiving
// [RL6] enable low stops at once, discards data
// [RL7] leaderless: short low pulse starts data
// [RL8] leaderless reception runs to last bit
// [RL9] same decode and completion with/without leader
// [RL10] invert bit flips sampled input
// [RL11] low-only leader: max low zero (the code checks only the leader cycle then)
// [RL12] completion raises interrupt, re-arms leader wait
// [RL13] phase mode decodes phase-coded frames
// [RL14] phase intervals classed as 1T/1.5T/2T
// [RL15] two seven-bit thresholds split the patterns
// [RL16] phase bits use pattern and previous data
// [RL17] phase result stored in three buffers
// [RL18] cycle at or above threshold is one
// [RL19] no fall within max cycle completes
// [RL20] first detected completion condition ends frame
// [RL21] all widths counted in sampling clock periods
// [RL22] completion resets counters, later frame overwrites
// [RL23] measure filtered, polarity-adjusted input
`timescale 1ns/1ps
`include "remote_rx_map.svh"
module remote_rx (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic sample_clk,
    input wire logic remote_in,
    input wire logic rx_enable,
    input wire logic leaderless_accept,
    input wire logic input_invert,
    input wire logic phase_mode_enable,
    input wire logic [`RX_CNT_W-1:0] leader_min_low,
    input wire logic [`RX_CNT_W-1:0] leader_max_low,
    input wire logic [`RX_CNT_W-1:0] leader_min_cycle,
    input wire logic [`RX_CNT_W-1:0] leader_max_cycle,
    input wire logic [`RX_CNT_W-1:0] low_width_limit,
    input wire logic [`RX_CNT_W-1:0] max_bit_cycle,
    input wire logic [`RX_THR_W-1:0] thresh_low,
    input wire logic [`RX_THR_W-1:0] thresh_high,
    input wire logic [`RX_NC_W-1:0] noise_cycles,
    input wire logic status_clear,
    input wire logic bit_word_ready,
    output logic [31:0] rx_buffer_a,
    output logic [31:0] rx_buffer_b,
    output logic [7:0] rx_buffer_c,
    output logic [`RX_IDX_W-1:0] rx_bit_count,
    output logic rx_irq,
    output logic rx_busy,
    output logic low_overflow_flag,
    output logic max_cycle_flag,
    output logic leader_flag,
    output logic overrun_flag,
    output logic bit_word_valid,
    output logic [`RX_FIFO_W-1:0] bit_word_data
);
    import remote_rx_pkg::*;

    rx_state_t state_q;
    pattern_t pat;
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic pin_s1_q, pin_s2_q;
    logic tick, raw, filt_q, filt_d, fall, rise;
    logic [`RX_NC_W-1:0] nc_q;
    logic [`RX_CNT_W-1:0] cyc_q, low_q, low_w_q;
    logic armed_q, phase_q, phase_d;
    logic [1:0] nbits;
    logic b0, b1, leader_ok, leader_hit, enter_data;
    logic max_done, low_done, done, push, fifo_ready;
    logic [`RX_IDX_W-1:0] cnt_q;
    logic [`RX_BUF_BITS-1:0] work_q;

    // two stages on every asynchronous input
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else if (clk_en) begin
            sclk_s1_q <= sample_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            pin_s1_q <= remote_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign tick = sclk_s2_q && !sclk_s3_q; // RL21
    assign raw = pin_s2_q ^ input_invert; // RL10

    // level changes only after noise_cycles agreeing samples
    always_comb begin
        filt_d = filt_q;
        if (tick && raw != filt_q && ({1'b0, nc_q} + 5'h1 >= {1'b0, noise_cycles})) begin
            filt_d = raw;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            filt_q <= 1'b1;
            nc_q <= '0;
        end else if (clk_en && tick) begin
            filt_q <= filt_d;
            if (raw == filt_q || filt_d != filt_q) begin
                nc_q <= '0;
            end else if (nc_q != 4'hf) begin
                nc_q <= nc_q + 4'h1;
            end
        end
    end

    assign fall = filt_q && !filt_d; // RL23
    assign rise = !filt_q && filt_d;

    // widths in sampling periods, saturating
    always_ff @(posedge clock) begin
        if (rst) begin
            cyc_q <= '0;
            low_q <= '0;
            low_w_q <= '0;
        end else if (clk_en && tick) begin
            if (fall || state_q == ST_IDLE) begin
                cyc_q <= '0;
                low_q <= '0;
            end else begin
                if (cyc_q != `RX_CNT_SAT) begin
                    cyc_q <= cyc_q + 8'h1;
                end
                if (!filt_q && low_q != `RX_CNT_SAT) begin
                    low_q <= low_q + 8'h1;
                end
            end
            if (rise) begin
                low_w_q <= low_q;
            end
        end
    end

    always_comb begin
        if (cyc_q < {1'b0, thresh_low}) begin
            pat = PAT_SHORT; // RL15
        end else if (cyc_q < {1'b0, thresh_high}) begin
            pat = PAT_MID;
        end else begin
            pat = PAT_LONG;
        end
    end

    // phase_q high: last fall sat mid-way through a one
    always_comb begin
        nbits = 2'h1;
        b0 = 1'b0;
        b1 = 1'b0;
        phase_d = phase_q;
        if (!phase_mode_enable) begin
            b0 = cyc_q >= {1'b0, thresh_low}; // RL18
        end else if (phase_q) begin
            case (pat) // RL14 RL16
                PAT_SHORT: b0 = 1'b1;
                PAT_MID: begin
                    nbits = 2'h2;
                    phase_d = 1'b0;
                end
                PAT_LONG: begin
                    nbits = 2'h2;
                    b1 = 1'b1;
                end
                default: nbits = 2'h0;
            endcase
        end else begin
            case (pat) // RL16
                PAT_SHORT: b0 = 1'b0;
                PAT_MID: begin
                    b0 = 1'b1;
                    phase_d = 1'b1;
                end
                default: nbits = 2'h0; // 2T from a boundary cannot occur
            endcase
        end
    end

    // cycle-only leader when max low is zero: the low width check is skipped
    assign leader_ok = (leader_max_low == '0 || (low_w_q >= leader_min_low && low_w_q <= leader_max_low))
        && cyc_q >= leader_min_cycle && cyc_q <= leader_max_cycle; // RL11
    assign leader_hit = state_q == ST_WAIT && clk_en && fall && armed_q && leader_max_cycle != '0 && leader_ok;
    assign enter_data = state_q == ST_WAIT && clk_en && rx_enable && ((fall && (leader_max_cycle == '0
        || (armed_q && leader_ok))) || (rise && armed_q && leaderless_accept && low_q < leader_max_low)); // RL4 RL7

    assign max_done = state_q == ST_DATA && tick && !fall && max_bit_cycle != '0 && cyc_q >= max_bit_cycle; // RL19
    assign low_done = state_q == ST_DATA && tick && !filt_d && low_width_limit != '0
        && low_q >= low_width_limit; // RL1
    assign done = clk_en && rx_enable && (max_done || low_done); // RL20 RL9
    assign push = clk_en && rx_enable && state_q == ST_DATA && fall && !done && nbits != 2'h0;

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            armed_q <= 1'b0;
        end else if (clk_en) begin
            if (!rx_enable) begin
                state_q <= ST_IDLE; // RL6
                armed_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        state_q <= ST_WAIT;
                        armed_q <= 1'b0;
                    end
                    ST_WAIT: begin
                        if (enter_data) begin
                            state_q <= ST_DATA;
                        end else if (fall) begin
                            armed_q <= 1'b1;
                        end
                    end
                    ST_DATA: begin
                        if (done) begin
                            state_q <= ST_WAIT; // RL12 RL8
                            armed_q <= 1'b0;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // a phase frame starts with a one: the entry fall sits mid-way through the first one
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
            phase_q <= 1'b1;
        end else if (clk_en) begin
            if (enter_data) begin
                cnt_q <= phase_mode_enable ? 7'h1 : 7'h0; // RL13
                phase_q <= 1'b1;
            end else if (state_q != ST_DATA || done) begin
                cnt_q <= '0; // RL22
            end else if (push) begin
                cnt_q <= (cnt_q + 7'(nbits) > 7'(`RX_BUF_BITS)) ? 7'(`RX_BUF_BITS) : cnt_q + 7'(nbits);
                phase_q <= phase_d;
            end
        end
    end

    generate
        for (genvar i = 0; i < `RX_BUF_BITS; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (rst) begin
                    work_q[i] <= 1'b0;
                end else if (clk_en) begin
                    if (enter_data) begin
                        work_q[i] <= (i == 0) && phase_mode_enable;
                    end else if (push && cnt_q == 7'(i)) begin
                        work_q[i] <= b0;
                    end else if (push && nbits == 2'h2 && 7'(cnt_q + 7'h1) == 7'(i)) begin
                        work_q[i] <= b1;
                    end
                end
            end
        end
    endgenerate

    // results move out only on completion, so a disabled frame leaves the buffers and bit count untouched
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_buffer_a <= '0;
            rx_buffer_b <= '0;
            rx_buffer_c <= '0;
            rx_bit_count <= '0;
            rx_irq <= 1'b0;
            rx_busy <= 1'b0;
        end else if (clk_en) begin
            rx_irq <= done; // RL2
            rx_busy <= rx_enable && (state_q == ST_DATA) && !done;
            if (done) begin
                rx_buffer_a <= work_q[31:0]; // RL17
                rx_buffer_b <= work_q[63:32];
                rx_buffer_c <= work_q[71:64];
                rx_bit_count <= cnt_q;
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clock) begin
        if (rst) begin
            low_overflow_flag <= 1'b0;
            max_cycle_flag <= 1'b0;
            leader_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else if (clk_en) begin
            low_overflow_flag <= (done && low_done) || (low_overflow_flag && !status_clear); // RL3
            max_cycle_flag <= (done && max_done) || (max_cycle_flag && !status_clear); // RL19
            leader_flag <= (leader_hit && rx_enable) || (leader_flag && !status_clear);
            overrun_flag <= (push && !fifo_ready) || (overrun_flag && !status_clear);
        end
    end

    // decoded bits also stream out; a full fifo drops the word and flags it
    rx_fifo #(
        .WIDTH(`RX_FIFO_W),
        .DEPTH(`RX_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({nbits == 2'h2, b1, b0}),
        .out_valid(bit_word_valid),
        .out_ready(bit_word_ready),
        .out_data(bit_word_data)
    );
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !clk_en);

    sequence finish_s;
        rx_enable && (max_done || low_done);
    endsequence
    disable_stops_a: assert property (!rx_enable |=> state_q == ST_IDLE && !rx_busy) // RL6
        else $error("disable did not stop reception");
    low_flag_a: assert property (rx_enable && low_done |=> low_overflow_flag) // RL3
        else $error("low overflow flag not set");
    done_irq_a: assert property (finish_s |=> rx_irq ##1 !rx_irq || $past(done)) // RL2
        else $error("completion interrupt wrong");
    max_flag_a: assert property (rx_enable && max_done |=> max_cycle_flag) // RL19
        else $error("max cycle flag not set");
    rearm_wait_a: assert property (finish_s |=> state_q == ST_WAIT && cnt_q == '0) // RL12
        else $error("no return to leader wait");
    thresh_bit_a: assert property (push && !phase_mode_enable && cnt_q != 7'h48 // RL18
        |=> work_q[$past(cnt_q)] == ($past(cyc_q) >= {1'b0, $past(thresh_low)}))
        else $error("threshold decision wrong");
    phase_class_a: assert property (push && phase_mode_enable && phase_q && cnt_q != 7'h48 // RL15
        |=> work_q[$past(cnt_q)] == ($past(cyc_q) < {1'b0, $past(thresh_low)}))
        else $error("phase pattern class wrong");
    wait_leader_a: assert property (state_q == ST_WAIT && !enter_data && rx_enable |=> state_q == ST_WAIT) // RL4
        else $error("left leader wait without start");
    buffer_load_a: assert property (finish_s |=> rx_buffer_a == $past(work_q[31:0])) // RL17
        else $error("buffer not loaded on completion");
endmodule : remote_rx

// [verification/ir_source.sv]
// behavioural remote control transmitter and its sampling clock
`timescale 1ns/1ps
module ir_source (
    output logic sample_clk,
    output logic remote_in,
    input wire logic clock
);
    // one tick per 8 system clocks instead of the slow crystal keeps runs short
    logic inv = 1'b0;
    int cnt = 0;
    initial begin
        sample_clk = 1'b0;
        remote_in = 1'b1;
    end
    always @(posedge clock) begin
        #1;
        cnt++;
        if (cnt % 4 == 0) begin
            sample_clk = ~sample_clk;
        end
    end
    // the line idles high between frames, low while inv is set, as hold applies inv to every level
    task automatic hold(input logic lvl, input int n);
        remote_in = lvl ^ inv;
        repeat (n) @(posedge sample_clk);
    endtask : hold
    task automatic leader();
        @(posedge sample_clk);
        hold(1'b0, 8);
        hold(1'b1, 8);
    endtask : leader
    // each cycle is a 2-tick low, then high up to the next fall; a trailing fall closes the last bit
    task automatic frame(input logic lead, input int cyc[$]);
        // start on a sampling edge so every hold spans whole ticks
        @(posedge sample_clk);
        if (lead) begin
            leader();
        end
        foreach (cyc[i]) begin
            hold(1'b0, 2);
            hold(1'b1, cyc[i] - 2);
        end
        hold(1'b0, 2);
        hold(1'b1, 1);
    endtask : frame
endmodule : ir_source

// [verification/remote_rx_tb.sv]
// self-checking bench for the remote control pulse receiver
`timescale 1ns/1ps
`include "remote_rx_map.svh"
module remote_rx_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic sample_clk, remote_in;
    logic rx_enable = 1'b0, leaderless_accept = 1'b0, input_invert = 1'b0, phase_mode_enable = 1'b0;
    logic status_clear = 1'b0, bit_word_ready = 1'b1;
    logic [`RX_CNT_W-1:0] leader_min_low = 8'h06, leader_max_low = 8'h0a, leader_min_cycle = 8'h0c;
    logic [`RX_CNT_W-1:0] leader_max_cycle = 8'h14, low_width_limit = 8'h0a, max_bit_cycle = 8'h10;
    logic [`RX_THR_W-1:0] thresh_low = 7'h05, thresh_high = 7'h07;
    logic [`RX_NC_W-1:0] noise_cycles = 4'h2;
    logic [31:0] rx_buffer_a, rx_buffer_b;
    logic [7:0] rx_buffer_c;
    logic [`RX_IDX_W-1:0] rx_bit_count;
    logic rx_irq, rx_busy, low_overflow_flag, max_cycle_flag, leader_flag, overrun_flag, bit_word_valid;
    logic [`RX_FIFO_W-1:0] bit_word_data;
    int errors = 0, check_count = 0;
    int cq[$];
    always #25 clock = ~clock;
    ir_source u_src (.sample_clk, .remote_in, .clock);
    remote_rx u_dut (.clock, .rst, .clk_en, .sample_clk, .remote_in, .rx_enable, .leaderless_accept,
        .input_invert, .phase_mode_enable, .leader_min_low, .leader_max_low, .leader_min_cycle,
        .leader_max_cycle, .low_width_limit, .max_bit_cycle, .thresh_low, .thresh_high, .noise_cycles,
        .status_clear, .bit_word_ready, .rx_buffer_a, .rx_buffer_b, .rx_buffer_c, .rx_bit_count, .rx_irq,
        .rx_busy, .low_overflow_flag, .max_cycle_flag, .leader_flag, .overrun_flag, .bit_word_valid,
        .bit_word_data);
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_done();
        int i;
        for (i = 0; i < 2000; i++) begin
            @(negedge clock);
            if (rx_irq === 1'b1) break;
        end
        if (i == 2000) begin
            errors++;
            $display("Error at %0t: no completion seen", $time);
            end_sim();
        end
    endtask : wait_done
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clock);
            chk(rx_irq, 1'b0);
        end
    endtask : quiet
    task automatic clear_flags();
        @(posedge clock);
        #1 status_clear = 1'b1;
        @(posedge clock);
        #1 status_clear = 1'b0;
        @(negedge clock);
        chk({low_overflow_flag, max_cycle_flag, leader_flag, overrun_flag}, 4'h0);
    endtask : clear_flags
    // settings only move between frames: a change mid-frame could corrupt the measurement
    task automatic cfg(input logic ld, input logic inv, input logic ph, input logic [7:0] max_low);
        @(posedge clock);
        #1 leaderless_accept = ld;
        input_invert = inv;
        phase_mode_enable = ph;
        leader_max_low = max_low;
        u_src.inv = inv;
        u_src.hold(1'b1, 3);
    endtask : cfg
    task automatic t_no_leader();
        cq = '{8, 4};
        u_src.frame(1'b0, cq);
        quiet(300);
        $display("test no_leader done");
    endtask : t_no_leader
    task automatic t_threshold();
        cq = '{8, 4, 8, 8, 4};
        u_src.frame(1'b1, cq);
        wait_done();
        chk(rx_buffer_a[4:0], 5'h0d);
        chk(rx_bit_count, 7'h05);
        chk({max_cycle_flag, low_overflow_flag, leader_flag, rx_busy}, 4'b1010);
        $display("test threshold done");
    endtask : t_threshold
    task automatic t_leaderless();
        clear_flags();
        cfg(1'b1, 1'b0, 1'b0, 8'h0a);
        cq = '{8, 4};
        u_src.frame(1'b0, cq);
        wait_done();
        chk(rx_buffer_a[1:0], 2'b01);
        chk(rx_bit_count, 7'h02);
        chk({max_cycle_flag, leader_flag, rx_busy}, 3'b100);
        cfg(1'b0, 1'b0, 1'b0, 8'h0a);
        $display("test leaderless done");
    endtask : t_leaderless
    task automatic t_excess();
        clear_flags();
        u_src.leader();
        u_src.hold(1'b0, 2);
        u_src.hold(1'b1, 6);
        u_src.hold(1'b0, 0);
        wait_done();
        chk({low_overflow_flag, max_cycle_flag}, 2'b10);
        chk(rx_bit_count, 7'h01);
        chk(rx_buffer_a[0], 1'b1);
        u_src.hold(1'b1, 4);
        $display("test excess_low done");
    endtask : t_excess
    task automatic t_abort();
        u_src.leader();
        u_src.hold(1'b0, 2);
        u_src.hold(1'b1, 6);
        chk(rx_busy, 1'b1);
        @(posedge clock);
        #1 rx_enable = 1'b0;
        repeat (2) @(negedge clock);
        chk(rx_busy, 1'b0);
        u_src.hold(1'b0, 2);
        u_src.hold(1'b1, 2);
        quiet(300);
        chk(rx_bit_count, 7'h01);
        @(posedge clock);
        #1 rx_enable = 1'b1;
        $display("test abort done");
    endtask : t_abort
    task automatic t_invert();
        clear_flags();
        cfg(1'b0, 1'b1, 1'b0, 8'h00);
        cq = '{4, 8, 8, 4, 8};
        u_src.frame(1'b1, cq);
        wait_done();
        chk(rx_buffer_a[4:0], 5'h16);
        chk({rx_bit_count, leader_flag}, {7'h05, 1'b1});
        cfg(1'b0, 1'b0, 1'b0, 8'h0a);
        $display("test invert done");
    endtask : t_invert
    task automatic t_phase();
        clear_flags();
        cfg(1'b0, 1'b0, 1'b1, 8'h0a);
        cq = '{4, 6, 4, 6, 8};
        u_src.frame(1'b1, cq);
        wait_done();
        chk(rx_buffer_a[7:0], 8'ha3);
        chk(rx_bit_count, 7'h08);
        chk({max_cycle_flag, rx_busy}, 2'b10);
        cfg(1'b0, 1'b0, 1'b0, 8'h0a);
        $display("test phase done");
    endtask : t_phase
    task automatic t_fill();
        int n;
        n = 0;
        clear_flags();
        @(posedge clock);
        #1 bit_word_ready = 1'b0;
        cq = {};
        for (int i = 0; i < 70; i++) begin
            cq.push_back((i % 2 == 1) ? 8 : 4);
        end
        u_src.frame(1'b1, cq);
        wait_done();
        chk({overrun_flag, rx_bit_count}, {1'b1, 7'h46});
        chk(rx_buffer_a, 32'haaaaaaaa);
        chk(rx_buffer_b, 32'haaaaaaaa);
        chk(rx_buffer_c, 8'h2a);
        @(posedge clock);
        #1 bit_word_ready = 1'b1;
        repeat (200) begin
            @(negedge clock);
            if (bit_word_valid === 1'b1) begin
                chk({bit_word_data[2], bit_word_data[0]}, {1'b0, n[0]});
                n++;
            end
        end
        chk(n >= 32, 1'b1);
        chk(bit_word_valid, 1'b0);
        $display("test fifo_fill done");
    endtask : t_fill
    initial begin
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        @(negedge clock);
        chk({rx_irq, rx_busy, low_overflow_flag, max_cycle_flag, leader_flag, overrun_flag}, 6'h0);
        @(posedge clock);
        #1 rx_enable = 1'b1;
        t_no_leader();
        t_threshold();
        t_leaderless();
        t_excess();
        t_abort();
        t_invert();
        t_phase();
        t_fill();
        end_sim();
    end
endmodule : remote_rx_tb
